// ---- pmc_pkg.sv ----
/*
 * Package for the power mode controller: register map, field layout,
 * mode enumeration and the packed carriers shared by the design files.
 * Assumes one 10 MHz clock and an AXI4-Lite register master.
 */
// Functional notes
// R1: full-on keeps pll running, not bypassed
// R2: power-up starts in full-on mode
// R3: active mode enables pll but bypasses it
// R4: active mode clocks run at input clock
// R5: active mode keeps l1 dma grant
// R6: active mode lets software turn pll off
// R7: software re-enables pll before full-on/sleep
// R8: sleep stops core clock, keeps system clock
// R9: sleep wake samples bypass bit
// R10: wake with bypass clear goes full-on
// R11: wake with bypass set goes active
// R12: sleep blocks system dma to l1
// R13: network wake leaves sleep
// R14: network wake restarts regulator in hibernate
// R15: per-peripheral clock enables
// R16: software sets core voltage anytime
// R17: deep sleep stops core and system clocks
// R18: deep sleep exits: reset full-on, rtc active
// R19: regulator frequency zero enters hibernate
// R20: hibernate wakes on rtc, network, reset, pin
// R21: mode requests needing pll refused while off
// R22: clock gates change only in low phase
package pmc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_PLL_CONTROL_REGISTER = 8'h00;   // pll_control_register
    localparam logic [7:0] ADDR_REGULATOR_CONTROL_REGISTER = 8'h04;    // regulator_control_register
    localparam logic [7:0] ADDR_WAKE_EN = 8'h08;   // wakeup_enable_register
    localparam logic [7:0] ADDR_PERIPH_EN = 8'h0c;
    localparam logic [7:0] ADDR_MODE_REQ = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam int NUM_PERIPH = 16;
    localparam int NUM_WAKE = 16;
    // pll control fields
    localparam int PLL_OFF_BIT = 0;
    localparam int PLL_BYPASS_BIT = 1;
    // regulator control fields
    localparam int VR_REGULATOR_FREQUENCY_FIELD_LSB = 0;
    localparam int VR_GAIN_LSB = 2;
    localparam int VR_VLEV_LSB = 4;
    localparam logic [1:0] VR_REGULATOR_FREQUENCY_FIELD_OFF = 2'h0;
    localparam logic [7:0] REGULATOR_CONTROL_REGISTER_RESET = 8'hb3;
    localparam logic [15:0] PERIPH_EN_RESET = 16'hffff;
    localparam logic [15:0] WAKE_EN_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // mode request codes written to the mode request register
    localparam logic [2:0] REQ_FULL_ON = 3'h0;
    localparam logic [2:0] REQ_ACTIVE = 3'h1;
    localparam logic [2:0] REQ_SLEEP = 3'h2;
    localparam logic [2:0] REQ_DEEP = 3'h3;

    typedef enum logic [2:0] {
        MODE_FULL_ON, MODE_ACTIVE, MODE_SLEEP, MODE_DEEP_SLEEP, MODE_HIBERNATE
    } mode_t;

    typedef struct packed {
        logic rtc;
        logic net;
        logic pin;
        logic [NUM_WAKE-1:0] irq;
    } wake_t;

    typedef struct packed {
        logic core_en;
        logic sys_en;
        logic [NUM_PERIPH-1:0] periph_en;
    } gate_req_t;
endpackage : pmc_pkg

// ---- pmc_clock_gate.sv ----
/*
 * Glitch-free clock enable generation for core, system and peripheral clocks.
 * Assumes the source clock is I_CLOCK; enables change only on the falling edge.
 */
`timescale 1ns/1ps
module pmc_clock_gate
    import pmc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire gate_req_t i_req,
    output logic o_core_clk,
    output logic o_sys_clk,
    output logic [NUM_PERIPH-1:0] o_periph_clk
);
    gate_req_t en_q;

    // enables latch while the clock is low so the and-gate never chops a pulse
    always_ff @(negedge i_clk) begin
        if (i_rst) begin
            en_q <= '0;
        end else begin
            en_q <= i_req; // R22
        end
    end

    assign o_core_clk = i_clk & en_q.core_en;
    assign o_sys_clk = i_clk & en_q.sys_en;

    // one gate per peripheral, each further qualified by the system clock
    genvar g;
    generate
        for (g = 0; g < NUM_PERIPH; g++) begin : g_periph
            assign o_periph_clk[g] = i_clk & en_q.sys_en & en_q.periph_en[g]; // R15
        end
    endgenerate

    // each high phase must show exactly the request taken at the falling edge before it
    property p_gate_low;
        @(negedge i_clk) disable iff (i_rst)
        !$past(i_rst) |-> en_q == $past(i_req);
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("clock enable not taken when low"); // R22
endmodule : pmc_clock_gate

// ---- pmc_top.sv ----
/*
 * Power mode controller: operating mode state, pll and regulator controls,
 * clock gating requests and wake-up handling, with an AXI4-Lite slave.
 * Assumes wake sources and pins are asynchronous and pass two flops here.
 */
`timescale 1ns/1ps
module pmc_top
    import pmc_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic I_RTC_WAKE,
    input wire logic I_NET_WAKE,
    input wire logic I_GENERAL_WAKE_PIN,
    input wire logic [NUM_WAKE-1:0] I_IRQ,
    output logic O_PLL_ENABLE,
    output logic O_PLL_BYPASS,
    output logic O_CORE_POWER,
    output logic [3:0] O_CORE_VLEVEL,
    output logic O_L1_DMA_GRANT,
    output logic O_CORE_CLOCK,
    output logic O_SYS_CLOCK,
    output logic [NUM_PERIPH-1:0] O_PERIPH_CLOCK
);
    typedef struct packed {
        mode_t mode;
        logic pll_off;
        logic pll_bypass;
        logic [7:0] regulator_control_register;
        logic [NUM_WAKE-1:0] wake_en;
        logic [NUM_PERIPH-1:0] periph_en;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] rtc_s;
        logic [1:0] net_s;
        logic [1:0] pin_s;
        logic [NUM_WAKE-1:0] irq_s1;
        logic [NUM_WAKE-1:0] irq_s2;
    } state_t;

    state_t q;
    state_t d;
    gate_req_t gate_req;
    logic wr_fire;
    logic wake_sleep;
    logic wake_hib;

    assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
    assign wake_sleep = (|(q.irq_s2 & q.wake_en)) || q.net_s[1] || q.rtc_s[1]; // R13
    assign wake_hib = q.rtc_s[1] || q.net_s[1] || q.pin_s[1]; // R14 R20

    // next-state: bus slave, registers, mode machine, synchronisers
    always_comb begin
        d = q;
        // two-flop synchronisers; only stage two is read by logic
        d.rtc_s = {q.rtc_s[0], I_RTC_WAKE};
        d.net_s = {q.net_s[0], I_NET_WAKE};
        d.pin_s = {q.pin_s[0], I_GENERAL_WAKE_PIN};
        d.irq_s1 = I_IRQ;
        d.irq_s2 = q.irq_s1;
        // write address and data accepted in either order
        if (I_AWVALID && !q.aw_have) begin
            d.aw_have = 1'b1;
            d.aw_addr = I_AWADDR;
        end
        if (I_WVALID && !q.w_have) begin
            d.w_have = 1'b1;
            d.w_data = I_WDATA;
        end
        if (q.bvalid && I_BREADY) begin
            d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            // byte strobes are ignored; every write updates the whole field, narrow registers ignore upper bits
            case (q.aw_addr)
                ADDR_PLL_CONTROL_REGISTER: begin
                    if (I_WSTRB[0] || 1'b1) begin
                        // pll may be switched off only from active mode
                        if (q.mode == MODE_ACTIVE) begin
                            d.pll_off = q.w_data[PLL_OFF_BIT]; // R6
                        end else begin
                            d.pll_off = 1'b0;
                        end
                        d.pll_bypass = q.w_data[PLL_BYPASS_BIT];
                    end
                end
                ADDR_REGULATOR_CONTROL_REGISTER: begin
                    d.regulator_control_register = q.w_data[7:0]; // R16
                    if (q.w_data[VR_REGULATOR_FREQUENCY_FIELD_LSB +: 2] == VR_REGULATOR_FREQUENCY_FIELD_OFF) begin
                        d.mode = MODE_HIBERNATE; // R19
                    end
                end
                ADDR_WAKE_EN: d.wake_en = q.w_data[NUM_WAKE-1:0];
                ADDR_PERIPH_EN: d.periph_en = q.w_data[NUM_PERIPH-1:0]; // R15
                ADDR_MODE_REQ: begin
                    case (q.w_data[2:0])
                        REQ_FULL_ON: begin
                            if (!q.pll_off) begin // R7 R21
                                d.mode = MODE_FULL_ON;
                                d.pll_bypass = 1'b0;
                            end else begin
                                d.bresp = RESP_SLVERR;
                            end
                        end
                        REQ_ACTIVE: begin
                            d.mode = MODE_ACTIVE;
                            d.pll_bypass = 1'b1; // R3
                        end
                        REQ_SLEEP: begin
                            if (!q.pll_off) begin // R21
                                d.mode = MODE_SLEEP;
                            end else begin
                                d.bresp = RESP_SLVERR;
                            end
                        end
                        REQ_DEEP: d.mode = MODE_DEEP_SLEEP;
                        default: d.bresp = RESP_SLVERR;
                    endcase
                end
                default: d.bresp = RESP_SLVERR;
            endcase
        end
        // wake-up handling
        case (q.mode)
            MODE_SLEEP: begin
                if (wake_sleep) begin
                    d.mode = q.pll_bypass ? MODE_ACTIVE : MODE_FULL_ON; // R9 R10 R11
                end
            end
            MODE_DEEP_SLEEP: begin
                if (q.rtc_s[1]) begin
                    d.mode = MODE_ACTIVE; // R18
                    d.pll_bypass = 1'b1;
                end
            end
            MODE_HIBERNATE: begin
                // regulator restarts at the default level and boots full-on
                if (wake_hib) begin
                    d.mode = MODE_FULL_ON; // R20
                    d.regulator_control_register = REGULATOR_CONTROL_REGISTER_RESET;
                    d.pll_bypass = 1'b0;
                    d.pll_off = 1'b0; // R1 full-on must never boot with the pll stopped
                end
            end
            default: ;
        endcase
        // read channel
        if (q.rvalid && I_RREADY) begin
            d.rvalid = 1'b0;
        end
        if (I_ARVALID && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            case (I_ARADDR)
                ADDR_PLL_CONTROL_REGISTER: begin
                    d.rdata[PLL_OFF_BIT] = q.pll_off;
                    d.rdata[PLL_BYPASS_BIT] = q.pll_bypass;
                end
                ADDR_REGULATOR_CONTROL_REGISTER: d.rdata[7:0] = q.regulator_control_register;
                ADDR_WAKE_EN: d.rdata[NUM_WAKE-1:0] = q.wake_en;
                ADDR_PERIPH_EN: d.rdata[NUM_PERIPH-1:0] = q.periph_en;
                ADDR_MODE_REQ: d.rdata[2:0] = q.mode;
                ADDR_STATUS: d.rdata[2:0] = q.mode;
                default: d.rresp = RESP_SLVERR;
            endcase
        end
    end

    // single state register; reset lands in full-on with pll running
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            q <= '0;
            q.mode <= MODE_FULL_ON; // R2 R18
            q.regulator_control_register <= REGULATOR_CONTROL_REGISTER_RESET;
            q.wake_en <= WAKE_EN_RESET;
            q.periph_en <= PERIPH_EN_RESET;
        end else begin
            q <= d;
        end
    end

    // clock gate requests per mode
    always_comb begin
        gate_req.core_en = (q.mode == MODE_FULL_ON) || (q.mode == MODE_ACTIVE); // R8 R17
        gate_req.sys_en = (q.mode != MODE_DEEP_SLEEP) && (q.mode != MODE_HIBERNATE); // R17
        gate_req.periph_en = q.periph_en;
    end

    pmc_clock_gate u_gate (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_req(gate_req),
        .o_core_clk(O_CORE_CLOCK),
        .o_sys_clk(O_SYS_CLOCK),
        .o_periph_clk(O_PERIPH_CLOCK)
    );

    // pll and supply controls straight from the state register
    assign O_PLL_ENABLE = !q.pll_off
        && (q.mode inside {MODE_FULL_ON, MODE_ACTIVE, MODE_SLEEP}); // R1
    // the bypass bit picks the wake target and drives the output only in sleep; active always bypasses, full-on never
    assign O_PLL_BYPASS = (q.mode == MODE_ACTIVE)
        || (q.mode == MODE_SLEEP && q.pll_bypass); // R1 R3 R4
    assign O_CORE_POWER = q.mode != MODE_HIBERNATE;
    assign O_CORE_VLEVEL = q.regulator_control_register[VR_VLEV_LSB +: 4];
    assign O_L1_DMA_GRANT = (q.mode == MODE_FULL_ON) || (q.mode == MODE_ACTIVE); // R5 R12
    assign O_AWREADY = !q.aw_have;
    assign O_WREADY = !q.w_have;
    assign O_BVALID = q.bvalid;
    assign O_BRESP = q.bresp;
    assign O_ARREADY = !q.rvalid;
    assign O_RVALID = q.rvalid;
    assign O_RDATA = q.rdata;
    assign O_RRESP = q.rresp;

    property p_sleep_wake;
        @(posedge I_CLOCK) disable iff (I_RST)
        (q.mode == MODE_SLEEP && wake_sleep && !q.pll_bypass) |=> q.mode == MODE_FULL_ON;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake not full-on"); // R10
    property p_sleep_act;
        @(posedge I_CLOCK) disable iff (I_RST)
        (q.mode == MODE_SLEEP && wake_sleep && q.pll_bypass) |=> q.mode == MODE_ACTIVE;
    endproperty
    a_sleep_act: assert property (p_sleep_act) else $error("sleep wake not active"); // R11
    property p_pll_gate;
        @(posedge I_CLOCK) disable iff (I_RST)
        q.pll_off |-> q.mode inside {MODE_ACTIVE, MODE_DEEP_SLEEP, MODE_HIBERNATE};
    endproperty
    a_pll_gate: assert property (p_pll_gate) else $error("pll off outside active"); // R21
    property p_full_on;
        @(posedge I_CLOCK) disable iff (I_RST)
        q.mode == MODE_FULL_ON |-> O_PLL_ENABLE && !O_PLL_BYPASS;
    endproperty
    a_full_on: assert property (p_full_on) else $error("full-on pll wrong"); // R1
    property p_dma;
        @(posedge I_CLOCK) disable iff (I_RST)
        q.mode == MODE_SLEEP |-> !O_L1_DMA_GRANT;
    endproperty
    a_dma: assert property (p_dma) else $error("dma granted in sleep"); // R12
    property p_hib;
        @(posedge I_CLOCK) disable iff (I_RST)
        (q.mode == MODE_HIBERNATE && wake_hib) |=> O_CORE_POWER;
    endproperty
    a_hib: assert property (p_hib) else $error("hibernate wake ignored"); // R20
    property p_deep;
        @(posedge I_CLOCK) disable iff (I_RST)
        (q.mode == MODE_DEEP_SLEEP && q.rtc_s[1]) |=> q.mode == MODE_ACTIVE && q.pll_bypass;
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep rtc exit wrong"); // R18
    property p_reset;
        @(posedge I_CLOCK) $fell(I_RST) |-> q.mode == MODE_FULL_ON;
    endproperty
    a_reset: assert property (p_reset) else $error("not full-on after reset"); // R2
    property p_active_byp;
        @(posedge I_CLOCK) disable iff (I_RST)
        q.mode == MODE_ACTIVE |-> O_PLL_BYPASS && O_CORE_POWER;
    endproperty
    a_active_byp: assert property (p_active_byp) else $error("active mode not bypassed"); // R3
    property p_sleep_clk;
        @(posedge I_CLOCK) disable iff (I_RST)
        q.mode == MODE_SLEEP |-> !gate_req.core_en && gate_req.sys_en;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("sleep clock gating wrong"); // R8
    property p_deep_clk;
        @(posedge I_CLOCK) disable iff (I_RST)
        q.mode == MODE_DEEP_SLEEP |-> !gate_req.core_en && !gate_req.sys_en;
    endproperty
    a_deep_clk: assert property (p_deep_clk) else $error("deep sleep clocks running"); // R17
    property p_hib_off;
        @(posedge I_CLOCK) disable iff (I_RST)
        q.mode == MODE_HIBERNATE |-> !O_CORE_POWER && !O_PLL_ENABLE;
    endproperty
    a_hib_off: assert property (p_hib_off) else $error("core powered in hibernate"); // R19
    c_sleep: cover property (@(posedge I_CLOCK)
        q.mode == MODE_SLEEP ##[1:50] q.mode == MODE_FULL_ON);
    c_hib: cover property (@(posedge I_CLOCK) q.mode == MODE_HIBERNATE ##[1:50] O_CORE_POWER);
    c_deep: cover property (@(posedge I_CLOCK)
        q.mode == MODE_DEEP_SLEEP ##[1:50] q.mode == MODE_ACTIVE);
endmodule : pmc_top

// ---- pmc_wake_src.sv ----
/*
 * Wake-up source model: rtc, network, wake pin and interrupt lines.
 * Assumes the bench pulses i_fire for one cycle per event.
 */
`timescale 1ns/1ps
module pmc_wake_src
    import pmc_pkg::*;
(
    input wire logic i_clk,
    input wire wake_t i_fire,
    output wake_t o_wake
);
    localparam int HOLD = 8;
    int cnt = 0;
    initial o_wake = '0;
    // hold long enough to pass the two-flop sync, then fall to the pull-down level
    always @(posedge i_clk) begin
        if (i_fire != '0) begin
            o_wake <= i_fire;
            cnt <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) o_wake <= '0;
        end
    end
endmodule : pmc_wake_src

// ---- tb_power_mode_controller.sv ----
/*
 * Bench for the power mode controller: AXI4-Lite register tasks and mode scenarios.
 * Assumes pmc_top and the wake source model; 10 MHz clock.
 */
`timescale 1ns/1ps
module tb_power_mode_controller import pmc_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pll_en, byp, cpow, dma, core_clock, sclk;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rv;
    logic [3:0] vlev;
    logic [15:0] pclk;
    wake_t fire = '0;
    wake_t wake;
    int num_errors = 0;
    int checks_done = 0;

    pmc_top pmc_top_i (.I_CLOCK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_RTC_WAKE(wake.rtc),
        .I_NET_WAKE(wake.net), .I_GENERAL_WAKE_PIN(wake.pin), .I_IRQ(wake.irq),
        .O_PLL_ENABLE(pll_en), .O_PLL_BYPASS(byp), .O_CORE_POWER(cpow),
        .O_CORE_VLEVEL(vlev), .O_L1_DMA_GRANT(dma), .O_CORE_CLOCK(core_clock),
        .O_SYS_CLOCK(sclk), .O_PERIPH_CLOCK(pclk));
    pmc_wake_src pmc_wake_src_i (.i_clk(clk), .i_fire(fire), .o_wake(wake));

    // clock source
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check

    // write, holding each channel until its own ready edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w, b;
        aw = 0;
        w = 0;
        b = 0;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b && n < 50) begin
            @(posedge clk);
            n++;
            if (aw && w && bvalid === 1'b1) begin
                b = 1;
                bready <= 1'b0;
                check("bresp", 32'(er), 32'(bresp));
            end
            if (!aw && awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        if (!b) check("bvalid", 32'h1, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        logic ar, got;
        ar = 0;
        got = 0;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got && n < 50) begin
            @(posedge clk);
            n++;
            if (ar && rvalid === 1'b1) begin
                got = 1;
                rv = rdata;
                rs = rresp;
                rready <= 1'b0;
            end
            if (!ar && arready === 1'b1) begin
                ar = 1;
                arvalid <= 1'b0;
            end
        end
        if (!got) check("rvalid", 32'h1, 32'h0);
    endtask : rd

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        rd(a);
        check("rresp", 32'(er), 32'(rs));
        if (er == RESP_OKAY) check(n, e, rv);
    endtask : rchk

    // polls status, since wake paths pass a synchroniser first
    task automatic wait_mode(input mode_t m);
        int k;
        k = 0;
        do begin
            rd(ADDR_STATUS);
            k++;
        end while (rv !== 32'(m) && k < 30);
        check("mode", 32'(m), rv);
    endtask : wait_mode

    // pll enable, bypass, dma grant, core power
    task automatic st(input logic [3:0] e);
        check("pll bypass grant power", 32'(e), 32'({pll_en, byp, dma, cpow}));
    endtask : st

    // high phase shows the enables, low phase must be quiet
    task automatic gates(input logic c, input logic s, input logic [15:0] p);
        @(posedge clk);
        #20;
        check("clocks high", 32'({c, s, p}), 32'({core_clock, sclk, pclk}));
        #55;
        check("clocks low", 32'h0, 32'({core_clock, sclk, pclk}));
    endtask : gates

    task automatic fire_ev(input wake_t f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= '0;
    endtask : fire_ev

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // watchdog: the sequence needs a few hundred cycles
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk("status", ADDR_STATUS, 32'(MODE_FULL_ON), RESP_OKAY);
        st(4'b1011);
        wr(ADDR_PLL_CONTROL_REGISTER, 32'h3, RESP_OKAY);
        st(4'b1011);
        rchk("pll_control_register", ADDR_PLL_CONTROL_REGISTER, 32'h2, RESP_OKAY);
        rchk("regulator", ADDR_REGULATOR_CONTROL_REGISTER, 32'(REGULATOR_CONTROL_REGISTER_RESET), RESP_OKAY);
        rchk("periph en", ADDR_PERIPH_EN, 32'(PERIPH_EN_RESET), RESP_OKAY);
        rchk("wake en", ADDR_WAKE_EN, 32'(WAKE_EN_RESET), RESP_OKAY);
        rchk("unmapped", 8'h1c, 32'h0, RESP_SLVERR);
        wr(8'h1c, 32'h0, RESP_SLVERR);
        wr(ADDR_MODE_REQ, 32'h7, RESP_SLVERR);
        rchk("mode", ADDR_MODE_REQ, 32'(MODE_FULL_ON), RESP_OKAY);
        wr(ADDR_MODE_REQ, 32'(REQ_ACTIVE), RESP_OKAY);
        wait_mode(MODE_ACTIVE);
        st(4'b1111);
        gates(1'b1, 1'b1, 16'hffff);
        wr(ADDR_PLL_CONTROL_REGISTER, 32'h3, RESP_OKAY);
        rchk("pll_control_register", ADDR_PLL_CONTROL_REGISTER, 32'h3, RESP_OKAY);
        st(4'b0111);
        wr(ADDR_MODE_REQ, 32'(REQ_FULL_ON), RESP_SLVERR);
        wr(ADDR_MODE_REQ, 32'(REQ_SLEEP), RESP_SLVERR);
        rchk("status", ADDR_STATUS, 32'(MODE_ACTIVE), RESP_OKAY);
        wr(ADDR_PLL_CONTROL_REGISTER, 32'h2, RESP_OKAY);
        wr(ADDR_WAKE_EN, 32'h8, RESP_OKAY);
        wr(ADDR_MODE_REQ, 32'(REQ_SLEEP), RESP_OKAY);
        wait_mode(MODE_SLEEP);
        st(4'b1101);
        gates(1'b0, 1'b1, 16'hffff);
        fire_ev({3'b000, 16'h0020});
        repeat (10) @(posedge clk);
        rchk("status", ADDR_STATUS, 32'(MODE_SLEEP), RESP_OKAY);
        fire_ev({3'b000, 16'h0008});
        wait_mode(MODE_ACTIVE);
        wr(ADDR_PLL_CONTROL_REGISTER, 32'h0, RESP_OKAY);
        st(4'b1111);
        wr(ADDR_MODE_REQ, 32'(REQ_SLEEP), RESP_OKAY);
        wait_mode(MODE_SLEEP);
        fire_ev({3'b010, 16'h0000});
        wait_mode(MODE_FULL_ON);
        st(4'b1011);
        wr(ADDR_MODE_REQ, 32'(REQ_DEEP), RESP_OKAY);
        wait_mode(MODE_DEEP_SLEEP);
        gates(1'b0, 1'b0, 16'h0000);
        fire_ev({3'b000, 16'h0008});
        repeat (10) @(posedge clk);
        rchk("status", ADDR_STATUS, 32'(MODE_DEEP_SLEEP), RESP_OKAY);
        fire_ev({3'b100, 16'h0000});
        wait_mode(MODE_ACTIVE);
        wr(ADDR_PERIPH_EN, 32'h5, RESP_OKAY);
        gates(1'b1, 1'b1, 16'h0005);
        wr(ADDR_REGULATOR_CONTROL_REGISTER, 32'h93, RESP_OKAY);
        check("vlevel", 32'h9, 32'(vlev));
        // each hibernate wake source in turn: rtc, network, pin
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_REGULATOR_CONTROL_REGISTER, 32'h90, RESP_OKAY);
            wait_mode(MODE_HIBERNATE);
            check("core power", 32'h0, 32'(cpow));
            fire_ev(wake_t'(19'h40000 >> i));
            wait_mode(MODE_FULL_ON);
            st(4'b1011);
            // the wake source holds its level for a while; let it and the sync drain
            repeat (12) @(posedge clk);
        end
        rchk("regulator", ADDR_REGULATOR_CONTROL_REGISTER, 32'(REGULATOR_CONTROL_REGISTER_RESET), RESP_OKAY);
        wr(ADDR_REGULATOR_CONTROL_REGISTER, 32'h90, RESP_OKAY);
        wait_mode(MODE_HIBERNATE);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rchk("status", ADDR_STATUS, 32'(MODE_FULL_ON), RESP_OKAY);
        st(4'b1011);
        final_report();
    end
endmodule : tb_power_mode_controller
